// ---- constant_output_ring_buffer.sv ----
// constant-output ring buffer: joined packet buffers replayed every period
// assumes period_start/period_end and result_full come from logic on clk
`timescale 1ns/10ps
`default_nettype none
`include "const_ring_defs.svh"
module constant_output_ring_buffer
  import const_ring_pkg::*;
#(
  parameter int STORE_BYTES = 768,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // period marks
  input wire logic period_start,
  input wire logic period_end,
  // constant byte stream to the periodic program
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data,
  // result packets
  input wire logic result_full,
  output logic result_send,
  // status
  output logic [3:0] in_buffers_free,
  output logic check_busy,
  output logic fatal_error
);
  initial begin
    if (STORE_BYTES != 768 || FIFO_DEPTH < 2) begin
      $error("store must hold twelve packet buffers");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // mode code to one-hot arrangement
  function automatic mode_t decode_mode(input logic [2:0] code);
    case (code)
      `CR_MODE_SIX_FIRST: decode_mode = mode_six_first;
      `CR_MODE_SIX_LAST: decode_mode = mode_six_last;
      `CR_MODE_EIGHT_FIRST: decode_mode = mode_eight_first;
      `CR_MODE_EIGHT_LAST: decode_mode = mode_eight_last;
      `CR_MODE_TEN_FIRST: decode_mode = mode_ten_first;
      `CR_MODE_TEN_LAST: decode_mode = mode_ten_last;
      `CR_MODE_TWELVE: decode_mode = mode_twelve;
      default: decode_mode = mode_off;
    endcase
  endfunction

  // store capacity of an arrangement in bytes
  function automatic logic [11:0] capacity(input mode_t m);
    case (m)
      mode_six_first, mode_six_last: capacity = `CR_CAP_SIX;
      mode_eight_first, mode_eight_last: capacity = `CR_CAP_EIGHT;
      mode_ten_first, mode_ten_last: capacity = `CR_CAP_TEN;
      mode_twelve: capacity = `CR_CAP_TWELVE;
      default: capacity = 12'h000;
    endcase
  endfunction

  // input buffers left for result packets
  function automatic logic [3:0] inputs_left(input mode_t m);
    case (m)
      mode_eight_first, mode_eight_last: inputs_left = `CR_IN_FOUR;
      mode_ten_first, mode_ten_last: inputs_left = `CR_IN_TWO;
      mode_twelve: inputs_left = `CR_IN_NONE;
      default: inputs_left = `CR_IN_SIX;
    endcase
  endfunction

  // true for 2^n with n from 0; callers exclude 1 where it must not count
  function automatic logic is_pow2(input logic [11:0] v);
    is_pow2 = (v != 12'h000) && ((v & (v - 12'h001)) == 12'h000);
  endfunction

  // wrap-check cost in cycles for a given length
  function automatic logic [3:0] latency(input logic [11:0] len);
    if (is_pow2(len) && len > 12'h001 && len <= 12'h100) begin
      latency = `CR_LAT_POW2;
    end else if (len == 12'h0ff) begin
      latency = `CR_LAT_255;
    end else if (len == 12'h200) begin
      latency = `CR_LAT_512;
    end else if (len == 12'h1ff) begin
      latency = `CR_LAT_511;
    end else if (len > 12'h100 && len < 12'h200 && is_pow2(len - 12'h100)) begin
      latency = `CR_LAT_256_POW2;
    end else if (len > 12'h200 && len <= 12'h280 && is_pow2(len - 12'h200)) begin
      latency = `CR_LAT_512_POW2;
    end else if (len < 12'h100) begin
      latency = `CR_LAT_BELOW_256;
    end else if (len < 12'h200) begin
      latency = `CR_LAT_BELOW_512;
    end else begin
      latency = `CR_LAT_GENERAL;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] store [STORE_BYTES];  // joined packet buffers
  mode_t mode_reg;  // current arrangement
  state_t state_reg;  // control sequence
  logic [11:0] len_reg;  // configured constant length
  logic [11:0] cons_reg;  // per-period consumption under analysis
  logic [11:0] rem_reg;  // remainder of the analysis division
  logic [11:0] ptr_reg;  // read pointer
  logic [11:0] load_reg;  // store load index
  logic [3:0] lat_reg;  // cycles left in the wrap check
  logic underrun_reg;  // reader asked past the end before a wrap
  logic pending_reg;  // a filled result packet waits for delivery
  logic ctrl_wr;  // mode write, also restarts the store
  logic fetch;  // one byte moves from store to fifo
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic take;  // output stage takes a fifo byte
  logic len_bad;  // length zero or above capacity
  logic first_variant;  // results handled at period start

  assign ctrl_wr = reg_wr && (reg_addr == `CR_ADDR_CTRL);
  assign len_bad = (len_reg == 12'h000) || (len_reg > capacity(mode_reg));
  assign first_variant = mode_reg[1] || mode_reg[3] || mode_reg[5];
  // no fetch while the pointer is checked: the wrap must not race a read
  assign fetch = (state_reg == st_run) && fifo_in_ready && !len_bad &&
                 (ptr_reg < len_reg);
  assign take = fifo_out_valid && (!byte_valid || byte_ready);

  ////////////////////////////////////////////////////////////////////////////
  // byte fifo in the data path

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .clear(ctrl_wr),
    .in_valid(fetch),
    .in_ready(fifo_in_ready),
    .in_data(store[ptr_reg[9:0]]),  // flat index
    .out_valid(fifo_out_valid),
    .out_ready(take),
    .out_data(fifo_out_data)
  );

  // output stage keeps the reader's ports on flip-flops
  always_ff @(posedge clk) begin
    if (!rst_b || ctrl_wr) begin
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else if (take) begin
      byte_valid <= 1'b1;
      byte_data <= fifo_out_data;
    end else if (byte_ready) begin
      byte_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // mode and length; length is free to change, checked at analysis time
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_reg <= mode_off;
      len_reg <= `CR_LEN_RESET;
      cons_reg <= `CR_CONS_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `CR_ADDR_CTRL: mode_reg <= decode_mode(reg_wdata[`CR_MODE_MSB:0]);
        `CR_ADDR_LEN: len_reg <= reg_wdata[11:0];
        `CR_ADDR_CONS: cons_reg <= reg_wdata[11:0];
        default: ;
      endcase
    end
  end

  // store load through the data register, auto-incrementing
  always_ff @(posedge clk) begin
    if (!rst_b || ctrl_wr) begin
      load_reg <= 12'h000;
    end else if (reg_wr && reg_addr == `CR_ADDR_DATA) begin
      if (load_reg < STORE_BYTES[11:0]) begin
        load_reg <= load_reg + 12'h001;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr == `CR_ADDR_DATA && load_reg < STORE_BYTES[11:0]) begin
      store[load_reg[9:0]] <= reg_wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control sequence: run, wrap check, program analysis

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= st_idle;
      lat_reg <= 4'h0;
      rem_reg <= 12'h000;
    end else if (ctrl_wr) begin
      // off returns to idle, any constant mode starts clean
      state_reg <= (reg_wdata[`CR_MODE_MSB:0] == `CR_MODE_OFF) ? st_idle : st_run;
    end else if (reg_wr && reg_addr == `CR_ADDR_CONS && state_reg != st_idle) begin
      state_reg <= st_analyze;
      rem_reg <= len_reg;
    end else begin
      case (state_reg)
        st_run: begin
          if (period_start) begin
            state_reg <= st_check;
            lat_reg <= latency(len_reg) - 4'h1;
          end
        end
        st_check: begin
          if (lat_reg == 4'h0) begin
            state_reg <= st_run;
          end else begin
            lat_reg <= lat_reg - 4'h1;
          end
        end
        st_analyze: begin
          // repeated subtraction; one step a cycle is plenty for setup time
          if (cons_reg != 12'h000 && rem_reg >= cons_reg) begin
            rem_reg <= rem_reg - cons_reg;
          end else begin
            state_reg <= st_run;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // read pointer: steps per fetch, wraps only when a check ends
  always_ff @(posedge clk) begin
    if (!rst_b || ctrl_wr) begin
      ptr_reg <= 12'h000;
    end else if (state_reg == st_check && lat_reg == 4'h0 && ptr_reg >= len_reg) begin
      ptr_reg <= 12'h000;
    end else if (fetch) begin
      ptr_reg <= ptr_reg + 12'h001;
    end
  end

  // fatal error from analysis; cleared by a mode write unless set then
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fatal_error <= 1'b0;
    end else if (state_reg == st_analyze &&
                 (cons_reg == 12'h000 || (rem_reg < cons_reg && rem_reg != 12'h000))) begin
      fatal_error <= 1'b1;
    end else if (state_reg == st_analyze && len_bad) begin
      fatal_error <= 1'b1;
    end else if (ctrl_wr) begin
      fatal_error <= 1'b0;
    end
  end

  // underrun: reader starved because the period used more than planned
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      underrun_reg <= 1'b0;
    end else if (state_reg == st_run && ptr_reg >= len_reg && byte_ready &&
                 !byte_valid && !fifo_out_valid) begin
      underrun_reg <= 1'b1;
    end else if (ctrl_wr) begin
      underrun_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result packet timing

  // pending packet; a new fill wins over the delivery clear
  always_ff @(posedge clk) begin
    if (!rst_b || ctrl_wr) begin
      pending_reg <= 1'b0;
      result_send <= 1'b0;
    end else begin
      result_send <= 1'b0;
      if (mode_reg != mode_twelve && pending_reg &&
          (first_variant ? period_start : period_end)) begin
        result_send <= 1'b1;
        pending_reg <= 1'b0;
      end
      if (result_full && mode_reg != mode_twelve) begin
        pending_reg <= 1'b1;
      end
    end
  end

  // status outputs on flip-flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      in_buffers_free <= `CR_IN_SIX;
      check_busy <= 1'b0;
    end else begin
      in_buffers_free <= inputs_left(mode_reg);
      check_busy <= (state_reg == st_check);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CR_ADDR_CTRL: reg_rdata <= {8'h00, mode_reg};
        `CR_ADDR_LEN: reg_rdata <= {4'h0, len_reg};
        `CR_ADDR_CONS: reg_rdata <= {4'h0, cons_reg};
        `CR_ADDR_STAT: reg_rdata <= {8'h00, in_buffers_free, underrun_reg, len_bad,
                                     check_busy, fatal_error};
        `CR_ADDR_PTR: reg_rdata <= {4'h0, ptr_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] busy_len_reg;  // counts cycles spent checking
  always_ff @(posedge clk) begin
    if (!rst_b || !check_busy) begin
      busy_len_reg <= 4'h1;
    end else begin
      busy_len_reg <= busy_len_reg + 4'h1;
    end
  end
  check_cost_a: assert property ($fell(check_busy) |->
    $past(busy_len_reg) == latency(len_reg))
    else $error("wrap check took the wrong number of cycles");
  pow2_cost_a: assert property (period_start && state_reg == st_run && !reg_wr &&
    len_reg == 12'h040 |=> ##1 check_busy ##1 check_busy ##1 !check_busy)
    else $error("power-of-two length check not two cycles");
  wrap_zero_a: assert property (state_reg == st_check && lat_reg == 4'h0 &&
    ptr_reg == len_reg && !ctrl_wr |=> ptr_reg == 12'h000)
    else $error("pointer did not return to zero");
  no_mid_wrap_a: assert property (state_reg == st_run && ptr_reg == len_reg &&
    !period_start && !ctrl_wr && !reg_wr |=> ptr_reg == len_reg)
    else $error("pointer wrapped outside a period start");
  ptr_step_a: assert property (fetch && !ctrl_wr |=> ptr_reg == $past(ptr_reg) + 12'h001)
    else $error("pointer did not step by one byte");
  mode_entry_a: assert property (ctrl_wr |=> ptr_reg == 12'h000 && !byte_valid)
    else $error("mode entry left a stale pointer");
  cap_limit_a: assert property (fetch |-> ptr_reg < capacity(mode_reg))
    else $error("read beyond the store capacity");
  twelve_none_a: assert property (mode_reg == mode_twelve && !$past(ctrl_wr) |->
    !result_send && in_buffers_free == `CR_IN_NONE ##1 !result_send)
    else $error("twelve-buffer mode produced a result");
  delay_first_a: assert property (first_variant && result_full && !ctrl_wr &&
    !period_start |=> !result_send)
    else $error("start variant delivered a result early");
  fatal_set_a: assert property (state_reg == st_analyze && cons_reg == 12'h000 &&
    !ctrl_wr |=> fatal_error)
    else $error("bad consumption gave no fatal error");
  width_a: assert property (ptr_reg <= `CR_CAP_TWELVE)
    else $error("pointer left the store");
  wrap_seen_c: cover property (state_reg == st_check && lat_reg == 4'h0 && ptr_reg == len_reg);
  cross_seen_c: cover property (fetch && ptr_reg == `CR_BUF_BYTES);
  fatal_seen_c: cover property ($rose(fatal_error));
  send_seen_c: cover property (result_send && first_variant);
endmodule
`default_nettype wire

// ---- const_ring_defs.svh ----
// constants for the constant-output ring buffer: offsets, fields, sizes, latencies
// assumes inclusion by bare name from the ring buffer and bench files
`ifndef CONST_RING_DEFS_SVH
`define CONST_RING_DEFS_SVH
// register word indices on the plain register port
`define CR_ADDR_CTRL 4'h0
`define CR_ADDR_LEN 4'h1
`define CR_ADDR_CONS 4'h2
`define CR_ADDR_DATA 4'h3
`define CR_ADDR_STAT 4'h4
`define CR_ADDR_PTR 4'h5
// control field: mode code in bits 2:0
`define CR_MODE_MSB 2
// mode codes written by configure_periodic_operation
`define CR_MODE_OFF 3'h0
`define CR_MODE_SIX_FIRST 3'h1
`define CR_MODE_SIX_LAST 3'h2
`define CR_MODE_EIGHT_FIRST 3'h3
`define CR_MODE_EIGHT_LAST 3'h4
`define CR_MODE_TEN_FIRST 3'h5
`define CR_MODE_TEN_LAST 3'h6
`define CR_MODE_TWELVE 3'h7
// packet buffer size and store capacities in bytes
`define CR_BUF_BYTES 12'h040
`define CR_CAP_SIX 12'h180
`define CR_CAP_EIGHT 12'h200
`define CR_CAP_TEN 12'h280
`define CR_CAP_TWELVE 12'h300
// free input buffers per mode
`define CR_IN_SIX 4'h6
`define CR_IN_FOUR 4'h4
`define CR_IN_TWO 4'h2
`define CR_IN_NONE 4'h0
// wrap-check cost in instruction cycles
`define CR_LAT_GENERAL 4'h8
`define CR_LAT_BELOW_512 4'h7
`define CR_LAT_BELOW_256 4'h4
`define CR_LAT_POW2 4'h2
`define CR_LAT_255 4'h3
`define CR_LAT_256_POW2 4'h5
`define CR_LAT_512_POW2 4'h6
`define CR_LAT_512 4'h3
`define CR_LAT_511 4'h5
// reset values
`define CR_LEN_RESET 12'h000
`define CR_CONS_RESET 12'h000
`endif

// ---- const_ring_pkg.sv ----
// types shared by the constant-output ring buffer
// assumes the defs header is on the include path
package const_ring_pkg;
  // buffer arrangement, one-hot
  typedef enum logic [7:0] {
    mode_off = 8'h01,
    mode_six_first = 8'h02,
    mode_six_last = 8'h04,
    mode_eight_first = 8'h08,
    mode_eight_last = 8'h10,
    mode_ten_first = 8'h20,
    mode_ten_last = 8'h40,
    mode_twelve = 8'h80
  } mode_t;
  // control sequence, one-hot
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_run = 4'h2,
    st_check = 4'h4,
    st_analyze = 4'h8
  } state_t;
endpackage

// ---- byte_fifo.sv ----
// small valid/ready fifo between the constant store and its reader
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("byte_fifo needs a power-of-two depth of at least 2");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [AW-1:0] wr_reg;  // write index
  logic [AW-1:0] rd_reg;  // read index
  logic [AW:0] cnt_reg;  // words held
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  // indices and count; clear empties the fifo at once
  always_ff @(posedge clk) begin
    if (!rst_b || clear) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- reader_model.sv ----
// model of the periodic program that pulls constant bytes from the ring buffer
// assumes byte_valid/byte_data come from logic on the same rising clk edge
`timescale 1ns/10ps
`default_nettype none
module reader_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench control: stall the reader on a fixed pattern
  input wire logic stall,
  // constant byte stream
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready
);
  logic [2:0] cnt_reg; // stall pattern counter
  logic [7:0] got[$]; // bytes taken, in arrival order
  // ready changes right after the edge; a slow reader still drains in order
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_reg <= 3'h0;
      byte_ready <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      byte_ready <= stall ? (cnt_reg[0] ^ cnt_reg[2]) : 1'b1;
    end
  end
  // take one byte per handshake, sequential reads only
  always_ff @(posedge clk) begin
    if (rst_b && byte_valid && byte_ready) begin
      got.push_back(byte_data);
    end
  end
endmodule
`default_nettype wire

// ---- tb_constant_output_ring_buffer.sv ----
// self-checking bench for the constant-output ring buffer
// assumes the design package and defs header are compiled and on the include path
`timescale 1ns/10ps
`default_nettype none
`include "const_ring_defs.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module tb_constant_output_ring_buffer;
  import const_ring_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic period_start = 1'b0, period_end = 1'b0, result_full = 1'b0, stall = 1'b0;
  logic byte_ready, byte_valid, result_send, check_busy, fatal_error;
  logic [7:0] byte_data;
  logic [3:0] in_buffers_free;
  logic [15:0] seed = 16'd35398; // fixed seed keeps runs repeatable
  logic [7:0] store [68]; // expected store contents
  int fails = 0, checks_done = 0, n, k, s1;
  int lens [13] = '{2, 64, 256, 255, 100, 1, 511, 300, 320, 257, 512, 513, 700};
  int ft [8][4] = '{'{1, 400, 100, 1}, '{1, 384, 128, 0}, '{3, 512, 128, 0}, '{5, 641, 1, 1},
    '{5, 640, 64, 0}, '{7, 768, 256, 0}, '{7, 68, 10, 1}, '{7, 68, 0, 1}};
  ////////////////////////////////////////////////////////////////////////////
  constant_output_ring_buffer dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .period_start(period_start), .period_end(period_end), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data), .result_full(result_full),
    .result_send(result_send), .in_buffers_free(in_buffers_free),
    .check_busy(check_busy), .fatal_error(fatal_error));
  reader_model rd_m (.clk(clk), .rst_b(rst_b), .stall(stall), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic bit pow2(input int x);
    return x > 0 && (x & (x - 1)) == 0;
  endfunction
  // wrap-check cost by length, most specific row first
  function automatic int lat(input int x);
    if (pow2(x) && x >= 2 && x <= 256) return 2;
    if (x == 255 || x == 512) return 3;
    if (x == 511) return 5;
    if (x > 256 && x <= 384 && pow2(x - 256)) return 5;
    if (x > 512 && x <= 640 && pow2(x - 512)) return 6;
    if (x < 256) return 4;
    if (x < 512) return 7;
    return 8;
  endfunction
  // free input buffers left by each mode code
  function automatic int free_of(input int m);
    return m <= 2 ? 6 : m <= 4 ? 4 : m <= 6 ? 2 : 0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data are taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // one-cycle pulse: 0 period start, 1 period end, 2 result full
  task automatic pulse(input int w);
    @(posedge clk);
    period_start <= (w == 0);
    period_end <= (w == 1);
    result_full <= (w == 2);
    @(posedge clk);
    {period_start, period_end, result_full} <= 3'b000;
  endtask
  // count cycles of check_busy following a period start
  task automatic busy_len();
    n = 0;
    repeat (30) begin
      @(posedge clk);
      #1 if (check_busy === 1'b1) n++;
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run of some 7000 cycles
  initial begin
    #(25 * 40000);
    fails++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1 `CHK("free_at_reset", 4'h6, in_buffers_free)
    rd(4'hf);
    `CHK("unmapped", 16'h0000, d)
    // every mode code: one-hot readback and free input buffers
    for (int m = 0; m < 8; m++) begin
      wr(`CR_ADDR_CTRL, 16'(m));
      rd(`CR_ADDR_CTRL);
      `CHK("ctrl_mode", 16'(1 << m), d)
      `CHK("in_free", 4'(free_of(m)), in_buffers_free)
    end
    // store of 68 bytes, consumption set to 17 per period, slow reader
    wr(`CR_ADDR_CTRL, 16'(`CR_MODE_TWELVE));
    rd_m.got.delete();
    stall <= 1'b1;
    for (int i = 0; i < 68; i++) begin
      seed = lfsr(seed);
      store[i] = seed[7:0];
      wr(`CR_ADDR_DATA, {8'h00, store[i]});
    end
    wr(`CR_ADDR_LEN, 16'd68);
    wr(`CR_ADDR_CONS, 16'd17);
    for (k = 0; k < 2000 && rd_m.got.size() < 68; k++) @(posedge clk);
    repeat (20) @(posedge clk);
    `CHK("held_till_period", 68, rd_m.got.size())
    rd(`CR_ADDR_PTR);
    `CHK("ptr_end", 16'd68, d)
    `CHK("good_len", 1'b0, fatal_error)
    pulse(0);
    busy_len();
    `CHK("busy_68", 4, n)
    for (k = 0; k < 2000 && rd_m.got.size() < 136; k++) @(posedge clk);
    for (int i = 0; i < 136; i++) begin
      `CHK("stream_byte", store[i % 68], rd_m.got[i])
    end
    // zero length stops fetching, so the pointer read back is the entry value
    wr(`CR_ADDR_LEN, 16'h0000);
    wr(`CR_ADDR_CTRL, 16'(`CR_MODE_TWELVE));
    rd(`CR_ADDR_PTR);
    `CHK("ptr_on_entry", 16'h0000, d)
    // wrap-check cost across the length classes
    foreach (lens[i]) begin
      wr(`CR_ADDR_CTRL, 16'(`CR_MODE_TWELVE));
      wr(`CR_ADDR_LEN, 16'(lens[i]));
      pulse(0);
      busy_len();
      `CHK("busy_len", lat(lens[i]), n)
    end
    // length against consumption and mode capacity
    foreach (ft[i]) begin
      wr(`CR_ADDR_CTRL, 16'(ft[i][0]));
      #1 `CHK("fatal_cleared", 1'b0, fatal_error)
      wr(`CR_ADDR_LEN, 16'(ft[i][1]));
      wr(`CR_ADDR_CONS, 16'(ft[i][2]));
      // let the analysis run out, else its late set would survive the next mode write
      repeat (700) @(posedge clk);
      `CHK("fatal", 1'(ft[i][3]), fatal_error)
      rd(`CR_ADDR_STAT);
      `CHK("stat_fatal", 1'(ft[i][3]), d[0])
    end
    // result delivery: start variants at the next period start, end variants at period end
    for (int m = 1; m < 8; m++) begin
      wr(`CR_ADDR_CTRL, 16'(m));
      pulse(2);
      pulse(0);
      #1 s1 = (result_send === 1'b1);
      pulse(1);
      #1 `CHK("send_at_start", 1'(m % 2 == 1 && m != 7), s1)
      `CHK("send_at_end", 1'(m % 2 == 0 && m != 7), result_send)
      @(posedge clk);
      #1 `CHK("send_one_cycle", 1'b0, result_send)
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
